/* rtl/csps_pkg.sv */
package csps_pkg;
    // instruction word layout
    localparam int INSTR_BITS = 16;
    localparam int ADDR_W     = 13;
    localparam int RD_BIT     = 15;
    localparam int WL_MSB     = 14;
    localparam int WL_LSB     = 13;
    localparam logic [1:0] WL_STREAM = 2'h3;
    // configuration byte at address zero
    localparam int CFG_ADDR     = 0;
    localparam int CFG_LSB_BIT  = 6;
    localparam int CFG_SRST_BIT = 5;
    localparam logic [7:0] MEM_RESET = 8'h00;
    // host register map on apb
    localparam logic [7:0] APB_CMD   = 8'h00;
    localparam logic [7:0] APB_WDATA = 8'h04;
    localparam logic [7:0] APB_RDATA = 8'h08;
    localparam logic [7:0] APB_STAT  = 8'h0c;
    localparam int CMD_GO_BIT  = 31;
    localparam int CMD_LSB_BIT = 16;
    localparam int CMD_CNT_LSB = 17;
    // timing: a link phase must outlast its minimum and the receiver's sync delay
    localparam int CORE_PERIOD_NS = 50;
    localparam int T_HIGH_NS      = 16;
    localparam int SYNC_CYC       = 3;
    localparam int HALF_MIN_CYC   = (T_HIGH_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS + SYNC_CYC;
endpackage

/* rtl/csps_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface csps_if;
    logic sclk;
    logic sel_n;
    logic h_out;
    logic h_oe_n;
    logic d_out;
    logic d_oe_n;
    logic sdio;
    // shared data line with a pull-up when neither end drives
    assign sdio = !h_oe_n ? h_out : (!d_oe_n ? d_out : 1'b1);
    modport host   (output sclk, output sel_n, output h_out, output h_oe_n, input sdio);
    modport device (input sclk, input sel_n, input sdio, output d_out, output d_oe_n);
endinterface
`default_nettype wire

/* rtl/csps_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module csps_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } csps_sync_t;
    csps_sync_t s_q, s_d;

    // only the second stage is visible outside
    always_comb begin
        s_d.meta = d;
        s_d.stab = s_q.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            // start at the pins' idle levels so no false edge follows reset
            s_q <= {INIT, INIT};
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.stab;
endmodule
`default_nettype wire

/* rtl/csps_dev.sv */
// How it works
// RULE1: ignore clock and data while deselected
// RULE2: frame opens on select low, clock rise
// RULE3: sixteen-bit instruction, then data bytes
// RULE4: select high between bytes stalls, keeps state
// RULE5: length code 11 streams until deselect
// RULE6: deselect mid-byte resets to new instruction
// RULE7: select tied low gives 2-wire mode
// RULE8: 2-wire streaming cannot be left
// RULE9: host avoids streaming in 2-wire mode
// RULE10: instruction carries read flag and length
// RULE11: readback turns data line to output
// RULE12: msb first at reset, config selects lsb
// RULE13: bits sampled on rising clock edge
// RULE14: enable on falling, release on rising
// RULE15: clock and select only inputs
// RULE16: config bit also sets address direction
// RULE17: codes 00,01,10 mean one to three
// RULE18: address advances after every data byte
`timescale 1ns/1ps
`default_nettype none
module csps_dev
    import csps_pkg::*;
#(
    parameter int MEM_BYTES = 16
) (
    input  wire logic              CORE_CLK,
    input  wire logic              RST_N,
    csps_if.device                 LINK,
    output logic                   CFG_LSB_FIRST,
    output logic                   WR_VALID,
    output logic [ADDR_W-1:0]      WR_ADDR,
    output logic [7:0]             WR_DATA,
    output logic                   BUSY
);
    localparam int AW = $clog2(MEM_BYTES);

    if (MEM_BYTES < 2 || MEM_BYTES > 8192 || (MEM_BYTES & (MEM_BYTES - 1)) != 0) begin : g_chk
        $error("MEM_BYTES must be a power of two from 2 to 8192");
    end

    typedef enum logic [0:0] {
        ST_INSTR = 1'b0,
        ST_DATA  = 1'b1
    } csps_dst_t;

    typedef struct packed {
        csps_dst_t                 st;
        logic [3:0]                bitcnt;
        logic [15:0]               sh;
        logic                      rd;
        logic [1:0]                wl;
        logic [ADDR_W-1:0]         addr;
        logic [1:0]                left;
        logic [7:0]                tx;
        logic                      sclk_p;
        logic                      sel_p;
        logic                      oe_n;
        logic                      dout;
        logic [MEM_BYTES-1:0][7:0] mem;
        logic                      wr_valid;
        logic [ADDR_W-1:0]         wr_addr;
        logic [7:0]                wr_data;
        logic                      busy;
    } csps_dstate_t;

    csps_dstate_t q, d;

    logic [2:0]        pins_s;
    logic              sclk_s;
    logic              sel_s;
    logic              din_s;
    logic              lsb;
    logic              rise;
    logic              fall;
    logic [15:0]       sh;
    logic [7:0]        rx_byte;
    logic [ADDR_W-1:0] na;
    logic              last;

    // every pin from the host crosses two flops before use
    csps_sync #(
        .W   (3),
        .INIT(3'b011)
    ) u_sync (
        .clk  (CORE_CLK),
        .rst_n(RST_N),
        .d    ({LINK.sclk, LINK.sel_n, LINK.sdio}),
        .q    (pins_s)
    );
    assign sclk_s = pins_s[2];
    assign sel_s  = pins_s[1];
    assign din_s  = pins_s[0];

    // register read; unmapped addresses return zero
    function automatic logic [7:0] mem_rd(input logic [MEM_BYTES-1:0][7:0] m,
                                          input logic [ADDR_W-1:0] a);
        if (int'(a) < MEM_BYTES) begin
            return m[a[AW-1:0]];
        end
        return 8'h00;
    endfunction

    // lsb-first walks upward, msb-first walks downward
    function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a, input logic up);
        return up ? ADDR_W'(a + 1'b1) : ADDR_W'(a - 1'b1); // RULE16 RULE18
    endfunction

    always_comb begin
        d          = q;
        d.wr_valid = 1'b0;
        d.sclk_p   = sclk_s;
        d.sel_p    = sel_s;
        lsb        = q.mem[CFG_ADDR][CFG_LSB_BIT]; // RULE12 RULE16
        // edges count only while selected
        rise       = sclk_s & ~q.sclk_p & ~sel_s; // RULE1 RULE2 RULE13
        fall       = ~sclk_s & q.sclk_p & ~sel_s; // RULE1 RULE14
        sh         = lsb ? {din_s, q.sh[15:1]} : {q.sh[14:0], din_s};
        rx_byte    = lsb ? sh[15:8] : sh[7:0];
        na         = step(q.addr, lsb);
        last       = (q.wl != WL_STREAM) && (q.left == 2'h0);
        if (sel_s) begin
            // a deselected port never drives the shared line
            d.oe_n = 1'b1; // RULE15
            if (!q.sel_p) begin
                // stall only on a byte boundary of a counted transfer
                if (q.bitcnt[2:0] != 3'h0 || (q.st == ST_DATA && q.wl == WL_STREAM)) begin
                    d.st     = ST_INSTR; // RULE4 RULE5 RULE6
                    d.bitcnt = 4'h0;
                end
            end
        end else if (rise) begin
            d.sh     = sh;
            d.bitcnt = q.bitcnt + 4'h1;
            if (q.st == ST_INSTR) begin
                if (q.bitcnt == 4'(INSTR_BITS - 1)) begin
                    d.rd     = sh[RD_BIT]; // RULE10
                    d.wl     = sh[WL_MSB:WL_LSB]; // RULE3 RULE17
                    d.left   = sh[WL_MSB:WL_LSB];
                    d.addr   = sh[ADDR_W-1:0];
                    d.st     = ST_DATA;
                    d.bitcnt = 4'h0;
                    d.tx     = mem_rd(q.mem, sh[ADDR_W-1:0]); // RULE11
                end
            end else if (q.bitcnt == 4'h7) begin
                d.bitcnt = 4'h0;
                if (!q.rd) begin
                    d.wr_valid = 1'b1;
                    d.wr_addr  = q.addr;
                    d.wr_data  = rx_byte;
                    if (int'(q.addr) == CFG_ADDR && rx_byte[CFG_SRST_BIT]) begin
                        // soft reset is self-clearing and restores every register
                        d.mem = '0;
                    end else if (int'(q.addr) < MEM_BYTES) begin
                        d.mem[q.addr[AW-1:0]] = rx_byte;
                    end
                end
                d.addr = na; // RULE18
                if (last) begin
                    // counted transfer done: next bits form a new instruction, also in 2-wire mode
                    d.st   = ST_INSTR; // RULE7
                    d.oe_n = 1'b1; // RULE14
                end else begin
                    // streaming never counts down, so only deselect leaves it
                    if (q.wl != WL_STREAM) begin
                        d.left = q.left - 2'h1; // RULE4
                    end
                    d.tx = mem_rd(q.mem, na); // RULE5 RULE8
                end
            end
        end else if (fall && q.st == ST_DATA && q.rd) begin
            // readback bits change on the falling edge so the host samples a settled rise
            d.oe_n = 1'b0; // RULE11 RULE14
            d.dout = lsb ? q.tx[0] : q.tx[7];
            d.tx   = lsb ? {1'b0, q.tx[7:1]} : {q.tx[6:0], 1'b0};
        end
        d.busy = (d.st == ST_DATA) || (d.bitcnt != 4'h0);
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            q        <= '0;
            q.sel_p  <= 1'b1;
            q.oe_n   <= 1'b1;
            q.mem    <= {MEM_BYTES{MEM_RESET}};
            q.st     <= ST_INSTR;
        end else begin
            q <= d;
        end
    end

    // all outputs come straight from the state register
    assign LINK.d_out   = q.dout;
    assign LINK.d_oe_n  = q.oe_n;
    assign CFG_LSB_FIRST = q.mem[CFG_ADDR][CFG_LSB_BIT];
    assign WR_VALID     = q.wr_valid;
    assign WR_ADDR      = q.wr_addr;
    assign WR_DATA      = q.wr_data;
    assign BUSY         = q.busy;
endmodule
`default_nettype wire

/* rtl/csps_host.sv */
`timescale 1ns/1ps
`default_nettype none
module csps_host
    import csps_pkg::*;
#(
    parameter int HALF_CYC = HALF_MIN_CYC
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  PADDR,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    csps_if.host             LINK
);
    if (HALF_CYC < HALF_MIN_CYC || HALF_CYC > 255) begin : g_chk
        $error("HALF_CYC out of range");
    end

    typedef enum logic [1:0] {
        H_IDLE = 2'h0,
        H_LOW  = 2'h1,
        H_HIGH = 2'h2,
        H_TAIL = 2'h3
    } csps_hst_t;

    typedef struct packed {
        csps_hst_t   st;
        logic [19:0] cmd;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic [7:0]  div;
        logic [5:0]  bitn;
        logic [5:0]  nbits;
        logic        sclk;
        logic        sel_n;
        logic        hout;
        logic        hoe_n;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } csps_hstate_t;

    csps_hstate_t q, d;
    logic         din_s;
    logic [47:0]  frame;
    logic [5:0]   idx;
    logic [5:0]   nidx;
    logic [2:0]   nbytes;
    logic         lsb;
    logic         rd;

    csps_sync #(
        .W   (1),
        .INIT(1'b1)
    ) u_sync (
        .clk  (CORE_CLK),
        .rst_n(RST_N),
        .d    (LINK.sdio),
        .q    (din_s)
    );

    // frame bit n to vector position: instruction in [15:0], byte k at 16+8k
    function automatic logic [5:0] pos(input logic [5:0] n, input logic l);
        if (l) begin
            return n;
        end
        return (n < 6'd16) ? (n ^ 6'h0f) : (n ^ 6'h07);
    endfunction

    always_comb begin
        d         = q;
        d.pready  = 1'b0;
        lsb       = q.cmd[CMD_LSB_BIT];
        rd        = q.cmd[RD_BIT];
        frame     = {q.wdata, q.cmd[15:0]};
        idx       = pos(q.bitn, lsb);
        nidx      = pos(6'(q.bitn + 6'd1), lsb);
        nbytes    = (PWDATA[WL_MSB:WL_LSB] == WL_STREAM) ?
                    3'(PWDATA[CMD_CNT_LSB+:2]) + 3'h1 : 3'(PWDATA[WL_MSB:WL_LSB]) + 3'h1;
        // apb: setup registers the answer, access phase presents it with pready
        if (PSEL && !PENABLE) begin
            d.pready  = 1'b1;
            d.pslverr = 1'b0;
            d.prdata  = 32'h0;
            if (PADDR == APB_CMD) begin
                d.prdata = {12'h0, q.cmd};
            end else if (PADDR == APB_WDATA) begin
                d.prdata = q.wdata;
            end else if (PADDR == APB_RDATA) begin
                d.prdata = q.rdata;
            end else if (PADDR == APB_STAT) begin
                d.prdata = {31'h0, q.st != H_IDLE};
            end else begin
                d.pslverr = 1'b1;
            end
        end
        // a new command while a frame runs is dropped
        if (PSEL && PENABLE && q.pready && PWRITE && q.st == H_IDLE) begin
            if (PADDR == APB_WDATA) begin
                d.wdata = PWDATA;
            end else if (PADDR == APB_CMD) begin
                d.cmd = PWDATA[19:0];
                if (PWDATA[CMD_GO_BIT]) begin
                    d.st    = H_LOW;
                    d.div   = 8'h0;
                    d.bitn  = 6'h0;
                    d.nbits = 6'(INSTR_BITS) + {nbytes, 3'h0};
                    d.sel_n = 1'b0;
                    d.sclk  = 1'b0;
                    d.hoe_n = 1'b0;
                    d.hout  = PWDATA[CMD_LSB_BIT] ? PWDATA[0] : PWDATA[15];
                    d.rdata = 32'h0;
                end
            end
        end
        if (q.st != H_IDLE) begin
            d.div = q.div + 8'h1;
        end
        if (q.div == 8'(HALF_CYC - 1)) begin
            d.div = 8'h0;
            case (q.st)
                H_LOW: begin
                    d.st   = H_HIGH;
                    d.sclk = 1'b1;
                end
                H_HIGH: begin
                    // sample late in the high phase to cover the device's sync delay
                    if (rd && q.bitn >= 6'd16) begin
                        d.rdata[5'(idx - 6'd16)] = din_s;
                    end
                    d.sclk = 1'b0;
                    d.bitn = q.bitn + 6'd1;
                    if (q.bitn + 6'd1 == q.nbits) begin
                        d.st    = H_TAIL;
                        d.hoe_n = 1'b1;
                    end else begin
                        d.st    = H_LOW;
                        d.hout  = frame[nidx];
                        d.hoe_n = rd && (q.bitn + 6'd1 >= 6'd16);
                    end
                end
                H_TAIL: begin
                    d.st    = H_IDLE;
                    d.sel_n = 1'b1;
                end
                default: begin
                    d.div = 8'h0;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            q       <= '0;
            q.st    <= H_IDLE;
            q.sel_n <= 1'b1;
            q.hoe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign PRDATA      = q.prdata;
    assign PREADY      = q.pready;
    assign PSLVERR     = q.pslverr;
    assign LINK.sclk   = q.sclk;
    assign LINK.sel_n  = q.sel_n;
    assign LINK.h_out  = q.hout;
    assign LINK.h_oe_n = q.hoe_n;
endmodule
`default_nettype wire

/* verification/csps_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// link watcher beside the host-to-device interface
module csps_checker (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic h_oe_n,
    input wire logic d_oe_n,
    input wire logic d_out
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    // two drivers at once would short the shared line
    AST_ONE_DRIVER: assert property (!(!h_oe_n && !d_oe_n))
        else $error("both ends drive the data line");
    AST_QUIET_DESEL: assert property (sel_n [*8] |-> d_oe_n)
        else $error("device drives while deselected");
    AST_IDLE_CLK: assert property (sel_n |-> !sclk)
        else $error("serial clock high outside a frame");
    AST_SEL_LEAD: assert property ($fell(sel_n) |-> !sclk [*4])
        else $error("clock rose too soon after select");
    AST_HIGH_PHASE: assert property ($rose(sclk) |-> sclk [*4])
        else $error("clock high phase too short");
    AST_LOW_PHASE: assert property ($fell(sclk) |-> !sclk [*4])
        else $error("clock low phase too short");
    AST_TURN: assert property ($fell(d_oe_n) |-> h_oe_n && !sel_n)
        else $error("device turned the line at a bad moment");
    // read data may only move while the clock is low
    AST_STABLE_HIGH: assert property (!d_oe_n && sclk && $past(sclk) |-> $stable(d_out))
        else $error("read data moved during clock high");
    AST_RELEASE: assert property ($rose(sel_n) |-> ##[0:6] d_oe_n)
        else $error("device kept the line after deselect");
endmodule
`default_nettype wire

/* verification/tb_config_serial_port_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_config_serial_port_slave
    import csps_pkg::*;
;
    logic              clk;
    logic              rst_n;
    logic [7:0]        paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              lsb1;
    logic              busy1;
    logic              wv1;
    logic              wv2;
    logic [ADDR_W-1:0] wa1;
    logic [ADDR_W-1:0] wa2;
    logic [7:0]        wd1;
    logic [7:0]        wd2;
    logic [31:0]       rdat;
    logic              serr;
    logic [31:0]       sh = 32'h0;
    logic [20:0]       wq[$];
    logic [20:0]       wq2[$];
    int                err_count;
    int                n_checks;

    csps_if lk1();
    csps_if lk2();

    csps_host i_csps_host (.CORE_CLK(clk), .RST_N(rst_n), .PADDR(paddr), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .LINK(lk1));
    csps_dev i_csps_dev (.CORE_CLK(clk), .RST_N(rst_n), .LINK(lk1), .CFG_LSB_FIRST(lsb1),
        .WR_VALID(wv1), .WR_ADDR(wa1), .WR_DATA(wd1), .BUSY(busy1));
    // second device faces the bench, which breaks the host's habits on purpose
    csps_dev i_csps_dev_b (.CORE_CLK(clk), .RST_N(rst_n), .LINK(lk2), .CFG_LSB_FIRST(),
        .WR_VALID(wv2), .WR_ADDR(wa2), .WR_DATA(wd2), .BUSY());
    csps_checker i_csps_checker (.CORE_CLK(clk), .RST_N(rst_n), .sclk(lk1.sclk),
        .sel_n(lk1.sel_n), .h_oe_n(lk1.h_oe_n), .d_oe_n(lk1.d_oe_n), .d_out(lk1.d_out));

    // clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // wire capture of the bits sampled on the first link, and write logs of both devices
    always @(posedge lk1.sclk) if (!lk1.sel_n) sh <= {sh[30:0], lk1.sdio};
    always @(posedge clk) begin
        if (wv1 === 1'b1) wq.push_back({wa1, wd1});
        if (wv2 === 1'b1) wq2.push_back({wa2, wd2});
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wchk(input bit b, input logic [12:0] a, input logic [7:0] d);
        logic [20:0] e;
        e = 21'h1fffff;
        if (!b && wq.size() > 0) e = wq.pop_front();
        if (b && wq2.size() > 0) e = wq2.pop_front();
        chk("write log", {11'h000, e}, {11'h000, a, d});
    endtask

    // apb master: holds the request until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no wait limit here: only the watchdog ends a hung access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] cmd(input logic rd, input logic [1:0] wl, input logic lsb,
                                        input logic [1:0] cnt, input logic [12:0] a);
        return {1'b1, 12'h000, cnt, lsb, rd, wl, a};
    endfunction

    // one host frame, then poll the status register until the host is idle
    task automatic xfer(input logic [31:0] c, input logic [31:0] wd);
        apb(1'b1, APB_WDATA, wd);
        apb(1'b1, APB_CMD, c);
        do begin
            apb(1'b0, APB_STAT, 32'h0);
        end while (rdat[0] !== 1'b0);
        repeat (8) @(posedge clk);
    endtask

    // bench-side host on the second link, msb first
    task automatic drv(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            lk2.h_out <= v[i];
            repeat (4) @(posedge clk);
            lk2.sclk <= 1'b1;
            repeat (4) @(posedge clk);
            lk2.sclk <= 1'b0;
        end
    endtask

    task automatic sel(input logic x);
        repeat (4) @(posedge clk);
        lk2.sel_n <= x;
        lk2.h_oe_n <= x;
    endtask

    task automatic s_reset();
        chk("lsb flag", {31'h0, lsb1}, 32'h0);
        chk("busy", {31'h0, busy1}, 32'h0);
        chk("idle line", {31'h0, lk1.sdio}, 32'h1);
    endtask

    task automatic s_lengths();
        logic [31:0] v;
        v = 32'h44332211;
        for (int c = 0; c < 3; c++) begin
            wq.delete();
            xfer(cmd(1'b0, c[1:0], 1'b0, 2'h0, 13'd12), v);
            if (c == 0) chk("wire", {8'h00, sh[23:0]}, 32'h000c11);
            chk("count", 32'(wq.size()), 32'(c + 1));
            for (int k = 0; k <= c; k++) wchk(1'b0, 13'd12 - k[12:0], v[8*k +: 8]);
        end
    endtask

    task automatic s_read();
        xfer(cmd(1'b1, 2'h2, 1'b0, 2'h0, 13'd12), 32'h0);
        apb(1'b0, APB_RDATA, 32'h0);
        chk("read data", rdat, 32'h00332211);
        chk("read writes", 32'(wq.size()), 32'h0);
    endtask

    task automatic s_stream();
        logic [31:0] v;
        v = 32'hd4c3b2a1;
        xfer(cmd(1'b0, WL_STREAM, 1'b0, 2'h3, 13'd15), v);
        chk("stream count", 32'(wq.size()), 32'h4);
        for (int k = 0; k < 4; k++) wchk(1'b0, 13'd15 - k[12:0], v[8*k +: 8]);
    endtask

    // switch to lsb first: addresses then climb, bits go out reversed
    task automatic s_lsb();
        xfer(cmd(1'b0, 2'h0, 1'b0, 2'h0, 13'd0), 32'h40);
        chk("lsb flag", {31'h0, lsb1}, 32'h1);
        wchk(1'b0, 13'd0, 8'h40);
        xfer(cmd(1'b0, 2'h1, 1'b1, 2'h0, 13'd2), 32'hbbaa);
        chk("wire lsb", sh, 32'h400455dd);
        wchk(1'b0, 13'd2, 8'haa);
        wchk(1'b0, 13'd3, 8'hbb);
        xfer(cmd(1'b1, 2'h1, 1'b1, 2'h0, 13'd2), 32'h0);
        apb(1'b0, APB_RDATA, 32'h0);
        chk("read lsb", {16'h0, rdat[15:0]}, 32'hbbaa);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped err", {31'h0, serr}, 32'h1);
        chk("unmapped data", rdat, 32'h0);
        // soft reset sent lsb first clears every byte, so msb first returns
        xfer(cmd(1'b0, 2'h0, 1'b1, 2'h0, 13'd0), 32'h20);
        chk("soft reset", {31'h0, lsb1}, 32'h0);
        wchk(1'b0, 13'd0, 8'h20);
    endtask

    // clocks while deselected, then a byte cut short, then a clean frame
    task automatic s_abort();
        wq2.delete();
        drv(32'h0, 24);
        sel(1'b0);
        drv({16'h0007, 4'h5}, 20);
        sel(1'b1);
        sel(1'b0);
        drv({16'h0008, 8'h3c}, 24);
        sel(1'b1);
        repeat (10) @(posedge clk);
        chk("abort count", 32'(wq2.size()), 32'h1);
        wchk(1'b1, 13'd8, 8'h3c);
    endtask

    task automatic s_stall();
        wq2.delete();
        sel(1'b0);
        drv({16'h2009, 8'h11}, 24);
        sel(1'b1);
        repeat (10) @(posedge clk);
        sel(1'b0);
        drv(32'h22, 8);
        sel(1'b1);
        repeat (10) @(posedge clk);
        chk("stall count", 32'(wq2.size()), 32'h2);
        wchk(1'b1, 13'd9, 8'h11);
        wchk(1'b1, 13'd8, 8'h22);
    endtask

    // select held low across three frames, the last one streaming
    task automatic s_twowire();
        wq2.delete();
        sel(1'b0);
        drv({16'h0005, 8'h5a}, 24);
        drv({16'h0006, 8'ha5}, 24);
        // a stream without select swallows what looks like a new instruction
        drv({16'h6004, 16'h0003}, 32);
        sel(1'b1);
        repeat (10) @(posedge clk);
        chk("two-wire count", 32'(wq2.size()), 32'h4);
        wchk(1'b1, 13'd5, 8'h5a);
        wchk(1'b1, 13'd6, 8'ha5);
        wchk(1'b1, 13'd4, 8'h00);
        wchk(1'b1, 13'd3, 8'h03);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        err_count = 0;
        n_checks = 0;
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        lk2.sclk = 1'b0;
        lk2.sel_n = 1'b1;
        lk2.h_out = 1'b0;
        lk2.h_oe_n = 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        s_reset();
        s_lengths();
        s_read();
        s_stream();
        s_lsb();
        s_abort();
        s_stall();
        s_twowire();
        wrap_up();
    end

    // watchdog, well beyond the expected run of some 4000 cycles
    initial begin
        #(50 * 60000);
        err_count++;
        wrap_up();
    end
endmodule
`default_nettype wire
